// ---- rtl/pmc_pkg.sv ----
package pmc_pkg;

	// ---------------------------------------------------------------
	// management register addresses and bit positions
	// ---------------------------------------------------------------
	localparam logic [4:0] REG_BASIC_MODE_CTRL = 5'h00;
	localparam logic [4:0] REG_TENBASE_CTRL    = 5'h18;
	localparam logic [4:0] REG_MODE_CONFIG     = 5'h19;
	localparam int         ISOLATE_BIT         = 10;
	localparam int         HEARTBEAT_OFF_BIT   = 7;
	localparam int         CFG_WIDTH           = 10;

	// ---------------------------------------------------------------
	// serial management frame figures
	// ---------------------------------------------------------------
	localparam logic [5:0] PREAMBLE_ONES = 6'h20;
	localparam logic [5:0] OP_LAST       = 6'h01;
	localparam logic [5:0] ADDR_LAST     = 6'h09;
	localparam logic [5:0] TA_LAST       = 6'h01;
	localparam logic [5:0] DATA_LAST     = 6'h0f;
	localparam logic [1:0] OP_READ       = 2'h2;
	localparam logic [1:0] OP_WRITE      = 2'h1;

	// cycles after reset release before straps are taken (sync depth + 1)
	localparam logic [1:0] STRAP_SETTLE  = 2'h3;

	// ---------------------------------------------------------------
	// types
	// ---------------------------------------------------------------
	typedef enum logic [1:0]
	{
		LAMP_NORMAL      = 2'h0,
		LAMP_RX_ONLY_CIM = 2'h1,
		LAMP_COMBO_CIM   = 2'h2,
		LAMP_COMBO_INTR  = 2'h3
	} pmc_lamp_t;

	// field order matches register bits 9:0
	typedef struct packed
	{
		logic      repeater;
		pmc_lamp_t activity_lamp_config;
		logic      duplex_lamp_config;
		logic      fiber_select;
		logic [4:0] station_addr_field;
	} pmc_cfg_t;

	localparam pmc_cfg_t CFG_RESET = '0;

	typedef struct packed
	{
		logic       repeater;
		logic       fiber;
		logic [4:0] station_addr_pins;
	} pmc_strap_t;

	typedef struct packed
	{
		logic rx_active;
		logic tx_active;
		logic full_duplex;
		logic speed100;
		logic polarity_rev;
		logic cim_status;
		logic intr;
	} pmc_link_t;

	typedef enum logic [2:0]
	{
		MG_PREAMBLE = 3'h0,
		MG_START    = 3'h1,
		MG_OPCODE   = 3'h2,
		MG_ADDRESS  = 3'h3,
		MG_TURN     = 3'h4,
		MG_DATA     = 3'h5
	} pmc_mgmt_t;

endpackage

// ---- rtl/pmc_sync.sv ----
`timescale 1ns/1ps
// two flop synchroniser for pins; first stage feeds only the second
module pmc_sync
	import pmc_pkg::*;
#(
	parameter int WIDTH = 1
)
(
	input  wire logic             clock_i,
	input  wire logic             nrst_i,
	input  wire logic [WIDTH-1:0] async_i,
	output logic      [WIDTH-1:0] sync_o
);

	logic [WIDTH-1:0] meta_reg;
	logic [WIDTH-1:0] sync_reg;

	// ---------------------------------------------------------------
	// two stages
	// ---------------------------------------------------------------
	always_ff @(posedge clock_i or negedge nrst_i)
	begin
		if (!nrst_i)
		begin
			meta_reg <= '0;
			sync_reg <= '0;
		end
		else
		begin
			meta_reg <= async_i;
			sync_reg <= meta_reg;
		end
	end

	assign sync_o = sync_reg;

endmodule

// ---- rtl/pmc_mode_config.sv ----
// Function
// [RULE1] repeater mode: carrier sense follows receive activity only
// [RULE2] node mode, half duplex: carrier sense on receive or transmit activity
// [RULE3] repeater mode at 100 Mb/s disables the carrier integrity check
// [RULE4] repeater mode forces heartbeat disable active
// [RULE5] repeater field loaded from strap at reset, writable afterwards
// [RULE6] lamp mode 11: rx lamp shows rx or tx, tx lamp shows interrupt
// [RULE7] lamp mode 10: rx lamp shows rx or tx, tx lamp shows integrity status
// [RULE8] lamp mode 01: rx lamp shows rx only, tx lamp shows integrity status
// [RULE9] lamp mode resets to 00: ordinary tx and rx activity lamps
// [RULE10] board must strap address bit 2 low when tx lamp shows integrity
// [RULE11] duplex lamp mode 1: polarity at 10 Mb/s, full duplex at 100 Mb/s
// [RULE12] duplex lamp mode 0 (reset): lamp shows full duplex always
// [RULE13] fiber select loaded from strap at reset, writable afterwards
// [RULE14] fiber mode drives far end fault enable and scrambler bypass
// [RULE15] software must disable auto-negotiation when enabling fiber mode
// [RULE16] station address pins captured at reset, field writable afterwards
// [RULE17] station address travels msb first, bit 4 leading
// [RULE18] captured all-zero address sets the isolate bit
// [RULE19] later zero address writes never isolate; only isolate writes do
// [RULE20] manager must know each station address to reach it
// [RULE21] heartbeat disable reads 1 in full duplex or repeater mode
`timescale 1ns/1ps
module pmc_mode_config
	import pmc_pkg::*;
(
	input  wire logic       clock_i,
	input  wire logic       nrst_i,
	input  wire logic       mdc_i,
	input  wire logic       mdio_i,
	input  wire logic       repeater_strap_i,
	input  wire logic       fiber_strap_i,
	input  wire logic [4:0] station_addr_pins_i,
	input  wire logic       rx_active_i,
	input  wire logic       tx_active_i,
	input  wire logic       full_duplex_i,
	input  wire logic       speed100_i,
	input  wire logic       polarity_rev_i,
	input  wire logic       cim_status_i,
	input  wire logic       intr_i,
	output logic            mdio_o,
	output logic            mdio_oe_o,
	output logic            crs_o,
	output logic            rx_activity_lamp_o,
	output logic            tx_activity_lamp_o,
	output logic            duplex_polarity_lamp_o,
	output logic            carrier_integrity_check_o,
	output logic            heartbeat_off_o,
	output logic            far_end_fault_on_o,
	output logic            scrambler_bypass_o,
	output logic            isolate_o
);

	// ---------------------------------------------------------------
	// pin synchronisers
	// ---------------------------------------------------------------
	pmc_strap_t strap_raw;
	pmc_strap_t strap_s;
	logic       mdc_s;
	logic       mdio_s;
	pmc_link_t  link;

	assign strap_raw = '{repeater: repeater_strap_i, fiber: fiber_strap_i,
		station_addr_pins: station_addr_pins_i};

	pmc_sync #(.WIDTH(9)) u_sync
	(
		.clock_i (clock_i),
		.nrst_i  (nrst_i),
		.async_i ({mdc_i, mdio_i, strap_raw}),
		.sync_o  ({mdc_s, mdio_s, strap_s})
	);

	// link status comes from logic on this clock, so no sync
	assign link = '{rx_active: rx_active_i, tx_active: tx_active_i,
		full_duplex: full_duplex_i, speed100: speed100_i,
		polarity_rev: polarity_rev_i, cim_status: cim_status_i, intr: intr_i};

	// ---------------------------------------------------------------
	// state declarations
	// ---------------------------------------------------------------
	pmc_cfg_t   cfg_reg,      cfg_next;
	logic       isolate_reg,  isolate_next;
	logic       hb_reg,       hb_next;
	logic [1:0] settle_reg,   settle_next;
	logic       done_reg,     done_next;
	pmc_mgmt_t  state_reg,    state_next;
	logic [5:0] cnt_reg,      cnt_next;
	logic [1:0] op_reg,       op_next;
	logic [9:0] addr_reg,     addr_next;
	logic [15:0] data_reg,    data_next;
	logic       hit_reg,      hit_next;
	logic       mdc_d_reg;
	logic       mdio_o_reg,   mdio_o_next;
	logic       mdio_oe_reg,  mdio_oe_next;
	logic       mdc_rise;
	logic       capture;
	logic       wr_commit;
	logic       hb_view;

	assign mdc_rise = mdc_s & ~mdc_d_reg;
	assign capture  = ~done_reg & (settle_reg == STRAP_SETTLE);

	// heartbeat disable as seen by software and the 10 Mb/s logic
	assign hb_view = hb_reg | link.full_duplex | cfg_reg.repeater; // [RULE4] [RULE21]

	// read image of the three registers this block answers for
	function automatic logic [15:0] read_word(input logic [4:0] regad,
		input pmc_cfg_t cfg, input logic iso, input logic hb);
		logic [15:0] w;
		w = '0;
		unique case (regad)
			REG_MODE_CONFIG:     w[CFG_WIDTH-1:0] = cfg;
			REG_BASIC_MODE_CTRL: w[ISOLATE_BIT] = iso;
			REG_TENBASE_CTRL:    w[HEARTBEAT_OFF_BIT] = hb;
			default:             w = '0;
		endcase
		return w;
	endfunction

	// ---------------------------------------------------------------
	// management frame engine: preamble, start, op, addresses, data
	// ---------------------------------------------------------------
	// preamble suppression is not supported: every frame needs 32 ones
	always_comb
	begin
		state_next   = state_reg;
		cnt_next     = cnt_reg;
		op_next      = op_reg;
		addr_next    = addr_reg;
		data_next    = data_reg;
		hit_next     = hit_reg;
		mdio_o_next  = mdio_o_reg;
		mdio_oe_next = mdio_oe_reg;
		wr_commit    = 1'b0;
		if (mdc_rise)
		begin
			unique case (state_reg)
				MG_PREAMBLE:
				begin
					mdio_oe_next = 1'b0;
					if (mdio_s)
						cnt_next = (cnt_reg == PREAMBLE_ONES) ? cnt_reg : cnt_reg + 6'h01;
					else if (cnt_reg == PREAMBLE_ONES)
					begin
						state_next = MG_START;
						cnt_next   = '0;
					end
					else
						cnt_next = '0;
				end
				MG_START:
				begin
					state_next = mdio_s ? MG_OPCODE : MG_PREAMBLE;
					cnt_next   = '0;
				end
				MG_OPCODE:
				begin
					op_next  = {op_reg[0], mdio_s};
					cnt_next = cnt_reg + 6'h01;
					if (cnt_reg == OP_LAST)
					begin
						state_next = MG_ADDRESS;
						cnt_next   = '0;
					end
				end
				MG_ADDRESS:
				begin
					// station address arrives msb first, bit 4 leading
					addr_next = {addr_reg[8:0], mdio_s}; // [RULE17]
					cnt_next  = cnt_reg + 6'h01;
					if (cnt_reg == ADDR_LAST)
					begin
						state_next = MG_TURN;
						cnt_next   = '0;
						hit_next   = (addr_next[9:5] == cfg_reg.station_addr_field) &&
							((op_reg == OP_READ) || (op_reg == OP_WRITE));
						data_next  = read_word(addr_next[4:0], cfg_reg, isolate_reg, hb_view);
					end
				end
				MG_TURN:
				begin
					cnt_next = cnt_reg + 6'h01;
					// first turnaround bit left floating, second driven low
					if (hit_reg && (op_reg == OP_READ) && (cnt_reg == '0))
					begin
						mdio_oe_next = 1'b1;
						mdio_o_next  = 1'b0;
					end
					if (cnt_reg == TA_LAST)
					begin
						state_next = MG_DATA;
						cnt_next   = '0;
						if (hit_reg && (op_reg == OP_READ))
						begin
							mdio_o_next = data_reg[15];
							data_next   = {data_reg[14:0], 1'b0};
						end
					end
				end
				MG_DATA:
				begin
					cnt_next = cnt_reg + 6'h01;
					if (op_reg == OP_READ)
					begin
						mdio_o_next = data_reg[15];
						data_next   = {data_reg[14:0], 1'b0};
					end
					else
						data_next = {data_reg[14:0], mdio_s};
					if (cnt_reg == DATA_LAST)
					begin
						state_next   = MG_PREAMBLE;
						cnt_next     = '0;
						mdio_oe_next = 1'b0;
						wr_commit    = hit_reg && (op_reg == OP_WRITE);
					end
				end
				default:
				begin
					state_next   = MG_PREAMBLE;
					cnt_next     = '0;
					mdio_oe_next = 1'b0;
				end
			endcase
		end
	end

	always_ff @(posedge clock_i or negedge nrst_i)
	begin
		if (!nrst_i)
		begin
			state_reg   <= MG_PREAMBLE;
			cnt_reg     <= '0;
			op_reg      <= '0;
			addr_reg    <= '0;
			data_reg    <= '0;
			hit_reg     <= 1'b0;
			mdc_d_reg   <= 1'b0;
			mdio_o_reg  <= 1'b0;
			mdio_oe_reg <= 1'b0;
		end
		else
		begin
			state_reg   <= state_next;
			cnt_reg     <= cnt_next;
			op_reg      <= op_next;
			addr_reg    <= addr_next;
			data_reg    <= data_next;
			hit_reg     <= hit_next;
			mdc_d_reg   <= mdc_s;
			mdio_o_reg  <= mdio_o_next;
			mdio_oe_reg <= mdio_oe_next;
		end
	end

	// ---------------------------------------------------------------
	// register file: strap capture and software writes
	// ---------------------------------------------------------------
	// straps are taken a few cycles after release, once synchronised;
	// writes before that are dropped so the strap value cannot be lost
	always_comb
	begin
		cfg_next     = cfg_reg;
		isolate_next = isolate_reg;
		hb_next      = hb_reg;
		settle_next  = settle_reg;
		done_next    = done_reg;
		if (!done_reg)
			settle_next = settle_reg + 2'h1;
		if (capture)
		begin
			done_next                     = 1'b1;
			cfg_next.repeater             = strap_s.repeater; // [RULE5]
			cfg_next.fiber_select         = strap_s.fiber; // [RULE13]
			cfg_next.station_addr_field   = strap_s.station_addr_pins; // [RULE16]
			cfg_next.activity_lamp_config = LAMP_NORMAL; // [RULE9]
			cfg_next.duplex_lamp_config   = 1'b0; // [RULE12]
			isolate_next = (strap_s.station_addr_pins == 5'h00); // [RULE18]
		end
		else if (wr_commit && done_reg)
		begin
			// a zero address written here leaves isolation alone
			unique case (addr_reg[4:0])
				REG_MODE_CONFIG:     cfg_next = pmc_cfg_t'(data_next[CFG_WIDTH-1:0]); // [RULE19]
				REG_BASIC_MODE_CTRL: isolate_next = data_next[ISOLATE_BIT]; // [RULE19]
				REG_TENBASE_CTRL:    hb_next = data_next[HEARTBEAT_OFF_BIT];
				default:             cfg_next = cfg_reg;
			endcase
		end
	end

	always_ff @(posedge clock_i or negedge nrst_i)
	begin
		if (!nrst_i)
		begin
			cfg_reg     <= CFG_RESET;
			isolate_reg <= 1'b0;
			hb_reg      <= 1'b0;
			settle_reg  <= '0;
			done_reg    <= 1'b0;
		end
		else
		begin
			cfg_reg     <= cfg_next;
			isolate_reg <= isolate_next;
			hb_reg      <= hb_next;
			settle_reg  <= settle_next;
			done_reg    <= done_next;
		end
	end

	// ---------------------------------------------------------------
	// carrier sense, lamps and internal mode outputs
	// ---------------------------------------------------------------
	logic crs_next;
	logic rx_lamp_next;
	logic tx_lamp_next;
	logic dup_lamp_next;
	logic cim_next;
	logic fiber_next;
	logic any_activity;

	assign any_activity = link.rx_active | link.tx_active;

	always_comb
	begin
		if (cfg_reg.repeater)
			crs_next = link.rx_active; // [RULE1]
		else if (link.full_duplex)
			crs_next = link.rx_active;
		else
			crs_next = any_activity; // [RULE2]
		cim_next = ~(cfg_reg.repeater & link.speed100); // [RULE3]
		unique case (cfg_reg.activity_lamp_config)
			LAMP_NORMAL:
			begin
				rx_lamp_next = link.rx_active; // [RULE9]
				tx_lamp_next = link.tx_active; // [RULE9]
			end
			LAMP_RX_ONLY_CIM:
			begin
				rx_lamp_next = link.rx_active; // [RULE8]
				tx_lamp_next = link.cim_status; // [RULE8]
			end
			LAMP_COMBO_CIM:
			begin
				rx_lamp_next = any_activity; // [RULE7]
				tx_lamp_next = link.cim_status; // [RULE7]
			end
			LAMP_COMBO_INTR:
			begin
				rx_lamp_next = any_activity; // [RULE6]
				tx_lamp_next = link.intr; // [RULE6]
			end
		endcase
		if (cfg_reg.duplex_lamp_config)
			dup_lamp_next = link.speed100 ? link.full_duplex : link.polarity_rev; // [RULE11]
		else
			dup_lamp_next = link.full_duplex; // [RULE12]
		fiber_next = cfg_reg.fiber_select; // [RULE14]
	end

	always_ff @(posedge clock_i or negedge nrst_i)
	begin
		if (!nrst_i)
		begin
			crs_o                     <= 1'b0;
			rx_activity_lamp_o        <= 1'b0;
			tx_activity_lamp_o        <= 1'b0;
			duplex_polarity_lamp_o    <= 1'b0;
			carrier_integrity_check_o <= 1'b0;
			heartbeat_off_o           <= 1'b0;
			far_end_fault_on_o        <= 1'b0;
			scrambler_bypass_o        <= 1'b0;
			isolate_o                 <= 1'b0;
		end
		else
		begin
			crs_o                     <= crs_next;
			rx_activity_lamp_o        <= rx_lamp_next;
			tx_activity_lamp_o        <= tx_lamp_next;
			duplex_polarity_lamp_o    <= dup_lamp_next;
			carrier_integrity_check_o <= cim_next;
			heartbeat_off_o           <= hb_view;
			far_end_fault_on_o        <= fiber_next;
			scrambler_bypass_o        <= fiber_next;
			isolate_o                 <= isolate_reg;
		end
	end

	assign mdio_o    = mdio_o_reg;
	assign mdio_oe_o = mdio_oe_reg;

	// ---------------------------------------------------------------
	// assertions
	// ---------------------------------------------------------------
	default clocking cb @(posedge clock_i); endclocking
	default disable iff (!nrst_i);

	AST_CRS_REPEATER: assert property ( // [RULE1]
		(cfg_reg.repeater && !link.rx_active && link.tx_active) |=> !crs_o)
		else $error("carrier sense raised by transmit in repeater mode");

	AST_CRS_NODE: assert property ( // [RULE2]
		(!cfg_reg.repeater && !link.full_duplex && any_activity) |=> crs_o)
		else $error("carrier sense missing in node half duplex");

	AST_CIM_OFF: assert property ( // [RULE3]
		(cfg_reg.repeater && link.speed100) |=> !carrier_integrity_check_o)
		else $error("integrity check left on in repeater 100 mode");

	AST_HB_FORCE: assert property ( // [RULE4]
		(cfg_reg.repeater || link.full_duplex) |=> heartbeat_off_o)
		else $error("heartbeat disable not forced");

	AST_STRAP_LOAD: assert property ( // [RULE5]
		capture |=> (cfg_reg.repeater == $past(strap_s.repeater)) &&
			(cfg_reg.fiber_select == $past(strap_s.fiber)) &&
			(cfg_reg.station_addr_field == $past(strap_s.station_addr_pins)))
		else $error("strap values not captured");

	AST_LAMP_INTR: assert property ( // [RULE6]
		(cfg_reg.activity_lamp_config == LAMP_COMBO_INTR) |=>
			(tx_activity_lamp_o == $past(link.intr)) &&
			(rx_activity_lamp_o == $past(any_activity)))
		else $error("lamp mode 11 wrong");

	AST_LAMP_COMBO_CIM: assert property ( // [RULE7]
		(cfg_reg.activity_lamp_config == LAMP_COMBO_CIM) |=>
			(tx_activity_lamp_o == $past(link.cim_status)) &&
			(rx_activity_lamp_o == $past(any_activity)))
		else $error("lamp mode 10 wrong");

	AST_LAMP_RX_CIM: assert property ( // [RULE8]
		(cfg_reg.activity_lamp_config == LAMP_RX_ONLY_CIM) |=>
			(tx_activity_lamp_o == $past(link.cim_status)) &&
			(rx_activity_lamp_o == $past(link.rx_active)))
		else $error("lamp mode 01 wrong");

	AST_DUP_LAMP: assert property ( // [RULE11]
		(cfg_reg.duplex_lamp_config && !link.speed100) |=>
			(duplex_polarity_lamp_o == $past(link.polarity_rev)))
		else $error("duplex lamp not showing polarity at 10 Mb/s");

	AST_FIBER: assert property ( // [RULE14]
		cfg_reg.fiber_select |=> far_end_fault_on_o && scrambler_bypass_o)
		else $error("fiber side effects missing");

	AST_ISO_ZERO: assert property ( // [RULE18]
		(capture && (strap_s.station_addr_pins == 5'h00)) |=> ##1 isolate_o)
		else $error("zero strap address did not isolate");

	AST_NO_ISO_WRITE: assert property ( // [RULE19]
		(done_reg && !(wr_commit && (addr_reg[4:0] == REG_BASIC_MODE_CTRL)))
			|=> (isolate_reg == $past(isolate_reg)))
		else $error("isolate changed without an isolate write");

endmodule

// ---- dv/pmc_mgmt_model.sv ----
`timescale 1ns/1ps
// station manager: clocks whole frames on the serial management pins
module pmc_mgmt_model
	import pmc_pkg::*;
(
	input  wire logic        clock_i,
	input  wire logic        mdio_i,
	output logic             mdc_o,
	output logic             mdio_o,
	output logic             mdio_oe_o,
	output logic [15:0]      rd_data_o,
	output logic             rd_valid_o
);
	// management clock rests low between frames
	initial
	begin
		mdc_o = 1'b0;
		mdio_o = 1'b1;
		mdio_oe_o = 1'b0;
		rd_data_o = '0;
		rd_valid_o = 1'b0;
	end

	// one bit slot: data set while low, sampled at the rise, 4 clocks high
	task automatic bit_cyc(input logic drive, input logic b, output logic s);
		@(negedge clock_i);
		mdio_oe_o = drive;
		mdio_o = b;
		repeat (4) @(negedge clock_i);
		mdc_o = 1'b1;
		s = mdio_i;
		repeat (4) @(negedge clock_i);
		mdc_o = 1'b0;
	endtask

	// full frame with fresh preamble; caller must know the station address
	task automatic frame(input logic [1:0] op, input logic [4:0] phy, input logic [4:0] reg_a,
		input logic [15:0] wdata);
		logic [63:0] bits;
		logic        s;
		logic        rd;
		rd = (op == OP_READ);
		bits = {32'hffffffff, 2'b01, op, phy, reg_a, 2'b10, wdata};
		// msb first for every field, address bit 4 leading
		for (int i = 63; i >= 0; i--)
		begin
			bit_cyc(!(rd && i < 18), bits[i], s);
			if (rd && i < 16)
				rd_data_o[i] = s;
		end
		@(negedge clock_i);
		mdio_oe_o = 1'b0;
		if (rd)
		begin
			rd_valid_o = 1'b1;
			@(negedge clock_i);
			rd_valid_o = 1'b0;
		end
	endtask
endmodule

// ---- dv/tb.sv ----
`timescale 1ns/1ps
module tb
	import pmc_pkg::*;
;
	logic        clock_i = 1'b0;
	logic        nrst_i = 1'b0;
	pmc_strap_t  strap = '0;
	pmc_link_t   lnk = '0;
	logic        mdc, mdio_wire, m_o, m_oe, d_o, d_oe, rd_valid;
	logic [15:0] rd_data;
	logic        crs, rx_l, tx_l, dup_l, cic, hb, fef, byp, iso;
	logic [15:0] exp_q[$];
	int          miscompares = 0;
	int          cmp_count = 0;
	logic        rep_m, fib_m, dup_m, hbw_m, iso_m;
	logic [1:0]  lamp_m;

	always #12.5 clock_i = ~clock_i;

	// open-drain style wire with pull-up when nobody drives
	assign mdio_wire = d_oe ? d_o : (m_oe ? m_o : 1'b1);

	pmc_mode_config i_dut (.clock_i(clock_i), .nrst_i(nrst_i), .mdc_i(mdc), .mdio_i(mdio_wire),
		.repeater_strap_i(strap.repeater), .fiber_strap_i(strap.fiber),
		.station_addr_pins_i(strap.station_addr_pins), .rx_active_i(lnk.rx_active),
		.tx_active_i(lnk.tx_active), .full_duplex_i(lnk.full_duplex), .speed100_i(lnk.speed100),
		.polarity_rev_i(lnk.polarity_rev), .cim_status_i(lnk.cim_status), .intr_i(lnk.intr),
		.mdio_o(d_o), .mdio_oe_o(d_oe), .crs_o(crs), .rx_activity_lamp_o(rx_l),
		.tx_activity_lamp_o(tx_l), .duplex_polarity_lamp_o(dup_l),
		.carrier_integrity_check_o(cic), .heartbeat_off_o(hb), .far_end_fault_on_o(fef),
		.scrambler_bypass_o(byp), .isolate_o(iso));

	pmc_mgmt_model i_mgr (.clock_i(clock_i), .mdio_i(mdio_wire), .mdc_o(mdc), .mdio_o(m_o),
		.mdio_oe_o(m_oe), .rd_data_o(rd_data), .rd_valid_o(rd_valid));

	// ---------------------------------------------------------------
	// comparison and closing
	// ---------------------------------------------------------------
	task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
		cmp_count++;
		if (seen !== exp)
		begin
			miscompares++;
			$display("MISMATCH %s expected %h seen %h", name, exp, seen);
		end
	endtask

	task automatic end_sim();
		$display("comparisons %0d mismatches %0d", cmp_count, miscompares);
		if (miscompares == 0 && cmp_count > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask

	// read results are paired with the oldest noted expectation
	always @(posedge clock_i)
	begin
		if (rd_valid === 1'b1)
		begin
			if (exp_q.size() == 0)
				check("read_unexpected", rd_data, 16'hdead);
			else
				check("read_data", rd_data, exp_q.pop_front());
		end
	end

	// ---------------------------------------------------------------
	// stimulus helpers
	// ---------------------------------------------------------------
	task automatic rd(input logic [4:0] phy, input logic [4:0] ra, input logic [15:0] exp);
		exp_q.push_back(exp);
		i_mgr.frame(OP_READ, phy, ra, 16'h0000);
	endtask

	// writes land after sync and register stages; 8 clocks covers both
	task automatic wr(input logic [4:0] phy, input logic [4:0] ra, input logic [15:0] d);
		i_mgr.frame(OP_WRITE, phy, ra, d);
		repeat (8) @(negedge clock_i);
	endtask

	task automatic do_reset(input pmc_strap_t s);
		@(negedge clock_i);
		nrst_i = 1'b0;
		strap = s;
		repeat (20) @(negedge clock_i);
		nrst_i = 1'b1;
		repeat (10) @(negedge clock_i);
	endtask

	// drive one link vector and compare every pin except mdio_o and mdio_oe_o against the mode model
	task automatic apply(input pmc_link_t l);
		logic tx_e;
		logic crs_e;
		logic rx_e;
		logic dup_e;
		@(negedge clock_i);
		lnk = l;
		repeat (2) @(negedge clock_i);
		tx_e  = (lamp_m == 2'h0) ? l.tx_active : ((lamp_m == 2'h3) ? l.intr : l.cim_status);
		crs_e = l.rx_active | (l.tx_active & !rep_m & !l.full_duplex);
		rx_e  = l.rx_active | (l.tx_active & lamp_m[1]);
		dup_e = (dup_m & !l.speed100) ? l.polarity_rev : l.full_duplex;
		check("crs", 16'(crs), 16'(crs_e));
		check("rx_lamp", 16'(rx_l), 16'(rx_e));
		check("tx_lamp", 16'(tx_l), 16'(tx_e));
		check("dup_lamp", 16'(dup_l), 16'(dup_e));
		check("integrity", 16'(cic), 16'(!(rep_m & l.speed100)));
		check("heartbeat", 16'(hb), 16'(hbw_m | l.full_duplex | rep_m));
		check("far_end", 16'(fef), 16'(fib_m));
		check("bypass", 16'(byp), 16'(fib_m));
		check("isolate", 16'(iso), 16'(iso_m));
	endtask

	// ---------------------------------------------------------------
	// main sequence
	// ---------------------------------------------------------------
	initial
	begin
		void'($urandom(80));
		// repeater and fiber straps high, zero address
		do_reset(pmc_strap_t'{repeater: 1'b1, fiber: 1'b1, station_addr_pins: 5'h00});
		{rep_m, fib_m, dup_m, hbw_m, iso_m, lamp_m} = {5'b11001, 2'h0};
		apply(7'h28);
		apply(7'h40);
		rd(5'h00, REG_MODE_CONFIG, 16'h0220);
		rd(5'h00, REG_BASIC_MODE_CTRL, 16'h0400);
		rd(5'h00, REG_TENBASE_CTRL, 16'h0080);
		wr(5'h00, REG_BASIC_MODE_CTRL, 16'h0000);
		iso_m = 1'b0;
		apply(7'h00);
		$display("test strap_repeater done");
		// node straps; board keeps address bit 2 low for integrity lamp
		do_reset(pmc_strap_t'{repeater: 1'b0, fiber: 1'b0, station_addr_pins: 5'h13});
		{rep_m, fib_m} = 2'b00;
		rd(5'h13, REG_MODE_CONFIG, 16'h0013);
		rd(5'h12, REG_MODE_CONFIG, 16'hffff);
		rd(5'h13, 5'h1f, 16'h0000);
		// a write aimed at another station must not turn repeater mode on
		wr(5'h12, REG_MODE_CONFIG, 16'h0200);
		apply(7'h20);
		$display("test strap_node done");
		// every lamp mode with both duplex lamp settings
		for (int m = 0; m < 4; m++)
		begin
			for (int d = 0; d < 2; d++)
			begin
				wr(5'h13, REG_MODE_CONFIG, 16'((m << 7) | (d << 6) | 16'h0013));
				lamp_m = 2'(m);
				dup_m = d[0];
				repeat (6) apply(pmc_link_t'(7'($urandom)));
			end
		end
		$display("test lamp_modes done");
		// software repeater, written heartbeat disable
		wr(5'h13, REG_MODE_CONFIG, 16'h0213);
		wr(5'h13, REG_TENBASE_CTRL, 16'h0080);
		{rep_m, hbw_m, lamp_m, dup_m} = {2'b11, 2'h0, 1'b0};
		repeat (8) apply(pmc_link_t'(7'($urandom)));
		// fiber on with zero address: no isolation, new address answers
		wr(5'h13, REG_MODE_CONFIG, 16'h0020);
		{rep_m, fib_m} = 2'b01;
		apply(pmc_link_t'(7'($urandom)));
		rd(5'h00, REG_MODE_CONFIG, 16'h0020);
		rd(5'h00, REG_BASIC_MODE_CTRL, 16'h0000);
		$display("test software_writes done");
		repeat (4) @(negedge clock_i);
		if (exp_q.size() != 0)
			check("pending_reads", 16'(exp_q.size()), 16'h0000);
		end_sim();
	end

	// hang guard
	initial
	begin
		repeat (100000) @(posedge clock_i);
		check("timeout", 16'h0001, 16'h0000);
		end_sim();
	end
endmodule
